// file: tb/rtc_dev_model.sv
// ====
// device model: sram with hidden serial clock
module rtc_dev_model #(
	// key and zero-bit layout are constants
	parameter logic [63:0] KEY       = 64'h0000_0000_0000_0000,
	parameter logic [63:0] ZERO_MASK = 64'h0000_0000_0000_0000,
	parameter int          ACC_NS = 100,
	parameter int          DAY    = 4
) (
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [12:0] addr,
	input  wire logic [7:0]  dq_out,
	input  wire logic        dq_oe,
	input  wire logic        rst_n,
	output logic      [7:0]  dq_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  ram [0:8191];
	logic [63:0] regs;
	logic [63:0] shd;
	logic [7:0]  dout;
	logic        bad;
	logic        open;
	int          ptr;
	int          cnt;
	// cycle decode, chip select gates all
	wire         rd = !ce_n && !oe_n && we_n;
	wire         wr = !ce_n && !we_n;
	// released lines show the inverse of the host byte
	assign dq_in = rd ? dout : (dq_oe ? dq_out : ~dq_out);
	// runs last far below one tick, so values stand
	// power-up contents
	initial begin
		foreach (ram[i]) ram[i] = 8'h00;
		regs = 64'h0000_0000_0000_0000;
		regs[DAY*8+4] = 1'b1;
		regs[DAY*8+5] = 1'b1;
		dout = 8'h00;
		bad = 1'b0;
		open = 1'b0;
		ptr = 0;
		cnt = 0;
	end
	// read start: inverted old data until access time passes
	always @(posedge rd) begin
		dout = ~dout;
		if (open) dout <= #(ACC_NS) {7'h00, regs[cnt]};
		else begin
			dout <= #(ACC_NS) ram[addr];
			ptr = 0;
			bad = 1'b0;
		end
	end
	always @(negedge rd) begin
		if (open) cnt = cnt + 1;
		if (cnt == 64) open = 1'b0;
	end
	// write end: key bit or data bit
	always @(negedge wr) begin
		if (open) begin
			shd[cnt] = dq_out[0];
			cnt = cnt + 1;
			if (cnt == 64) begin
				regs = shd & ~ZERO_MASK;
				open = 1'b0;
			end
		end else begin
			ram[addr] = dq_out;
			if (!bad && dq_out[0] === KEY[ptr]) ptr = ptr + 1;
			else bad = 1'b1;
			if (ptr == 64) begin
				open = 1'b1;
				cnt = 0;
				ptr = 0;
			end
		end
	end
	always @(negedge rst_n) if (!regs[DAY*8+4]) open = 1'b0;
endmodule : rtc_dev_model

// file: tb/serial_rtc_pattern_access_bench.sv
// ====
// bench for the clock access controller
module serial_rtc_pattern_access_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [63:0] KEY_VAL = 64'h5A3C_96E1_0F87_D24B; // arbitrary key
	localparam logic [12:0] SCR     = 13'h1FFF;
	logic                    hclk;
	logic                    hresetn;
	logic                    hsel;
	logic                    hwrite;
	logic [7:0]              haddr;
	logic [1:0]              htrans;
	logic [2:0]              hsize;
	logic [31:0]             hwdata;
	logic                    hreadyout;
	logic                    hresp;
	logic [31:0]             hrdata;
	rtc_host_pkg::sram_out_s sram_out;
	logic [7:0]              dq_in;
	logic                    rst_pin_n;
	int                      miscompares;
	int                      n_checks;
	int                      cyc;
	logic [7:0]              ram_exp [int];
	logic [63:0]             t_exp;
	logic [31:0]             r;
	logic [12:0]             a;
	rtc_host #(.KEY(KEY_VAL)) rtc_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.sram_out(sram_out), .dq_in(dq_in), .rst_pin_n(rst_pin_n));
	rtc_dev_model #(.KEY(KEY_VAL), .ACC_NS(120)) rtc_dev_model_i (.ce_n(sram_out.ce_n),
		.oe_n(sram_out.oe_n), .we_n(sram_out.we_n), .addr(sram_out.addr),
		.dq_out(sram_out.dq_out), .dq_oe(sram_out.dq_oe), .rst_n(rst_pin_n), .dq_in(dq_in));
	// clock
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// hang guard
	always @(posedge hclk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			miscompares = miscompares + 1;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("BAD %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one single word transfer, answer taken at the second ready edge
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= ad;
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic go(input rtc_host_pkg::op_e code);
		bus(1'b1, rtc_host_pkg::OFS_CTRL, {28'h000_0000, 1'b0, code, 1'b1});
	endtask : go
	task automatic done_wait;
		do bus(1'b0, rtc_host_pkg::OFS_STATUS, 32'h0000_0000);
		while (r[rtc_host_pkg::STAT_DONE] !== 1'b1);
		bus(1'b1, rtc_host_pkg::OFS_STATUS, 32'h0000_0002);
		bus(1'b0, rtc_host_pkg::OFS_STATUS, 32'h0000_0000);
		chk(r[1:0], 2'b00);
	endtask : done_wait
	task automatic put_time(input logic [63:0] v);
		bus(1'b1, rtc_host_pkg::OFS_TIME_LO, v[31:0]);
		bus(1'b1, rtc_host_pkg::OFS_TIME_HI, v[63:32]);
	endtask : put_time
	task automatic get_time(input logic [63:0] v);
		bus(1'b0, rtc_host_pkg::OFS_TIME_LO, 32'h0000_0000);
		chk(r, v[31:0]);
		bus(1'b0, rtc_host_pkg::OFS_TIME_HI, 32'h0000_0000);
		chk(r, v[63:32]);
	endtask : get_time
	// main sequence
	initial begin
		{hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
		miscompares = 0;
		n_checks = 0;
		cyc = 0;
		void'($urandom(52102));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, rtc_host_pkg::OFS_STATUS, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		chk({hreadyout, hresp}, 2'b10);
		bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
		bus(1'b0, 8'h1C, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		chk(rst_pin_n, 1'b1);
		repeat (3) begin
			a = 13'($urandom) & 13'h0FFF;
			ram_exp[a] = 8'($urandom);
			bus(1'b1, rtc_host_pkg::OFS_ADDR, {19'h0_0000, a});
			bus(1'b1, rtc_host_pkg::OFS_WDATA, {24'h00_0000, ram_exp[a]});
			go(rtc_host_pkg::OP_RAM_WRITE);
			done_wait();
			chk(rtc_dev_model_i.ram[a], ram_exp[a]);
			go(rtc_host_pkg::OP_RAM_READ);
			done_wait();
			bus(1'b0, rtc_host_pkg::OFS_RDATA, 32'h0000_0000);
			chk(r[7:0], ram_exp[a]);
		end
		bus(1'b1, rtc_host_pkg::OFS_ADDR, {19'h0_0000, SCR});
		repeat (3) begin
			t_exp = {$urandom, $urandom};
			put_time(t_exp);
			go(rtc_host_pkg::OP_CLK_WRITE);
			put_time(~t_exp);
			done_wait();
			chk(rtc_dev_model_i.regs, t_exp);
			chk(rtc_dev_model_i.ram[SCR], {7'h00, KEY_VAL[63]});
			chk(rtc_dev_model_i.open, 1'b0);
			put_time(~t_exp);
			go(rtc_host_pkg::OP_CLK_READ);
			done_wait();
			get_time(t_exp);
		end
		t_exp[36] = 1'b0;
		put_time(t_exp);
		go(rtc_host_pkg::OP_CLK_WRITE);
		done_wait();
		put_time(~t_exp);
		go(rtc_host_pkg::OP_CLK_WRITE);
		wait (rtc_dev_model_i.open === 1'b1);
		repeat (20) @(posedge hclk);
		bus(1'b1, rtc_host_pkg::OFS_CTRL, 32'h0000_0008);
		@(posedge hclk);
		chk(rst_pin_n, 1'b0);
		bus(1'b1, rtc_host_pkg::OFS_CTRL, 32'h0000_0000);
		done_wait();
		chk(rtc_dev_model_i.regs, t_exp);
		go(rtc_host_pkg::OP_CLK_READ);
		done_wait();
		get_time(t_exp);
		print_verdict();
	end
endmodule : serial_rtc_pattern_access_bench

// file: verilog/rtc_host.sv
// Notes on behaviour
// - 64 matching key writes on lsb unlock
// - opening read resets the key pointer
// - key writes use one scratch address
// - one bit per cycle; read drives, write accepts
// - host moves whole 8-bit register groups
// - order bit 0 reg 0 to bit 7 reg 7
// - read is output enable low, write enable high
// - write spans both strobes low
//
// The address map and the AHB-Lite slave port were decided locally.
module rtc_host #(
	parameter logic [63:0] KEY = 64'h0123_4567_89AB_CDEF
) (
	input  wire logic                             hclk,
	input  wire logic                             hresetn,
	input  wire logic                             hsel,
	input  wire logic [7:0]                       haddr,
	input  wire logic [1:0]                       htrans,
	input  wire logic                             hwrite,
	input  wire logic [2:0]                       hsize,
	input  wire logic [31:0]                      hwdata,
	input  wire logic                             hready,
	output logic                                  hreadyout,
	output logic      [31:0]                      hrdata,
	output logic                                  hresp,
	output rtc_host_pkg::sram_out_s               sram_out,
	input  wire logic [7:0]                       dq_in,
	output logic                                  rst_pin_n
);

	// ==========================================================
	// state
	rtc_host_pkg::state_e        state_reg;
	rtc_host_pkg::op_e           op_reg;
	rtc_host_pkg::sram_out_s     pins_reg;
	logic [7:0]                  step_reg;
	logic [2:0]                  cnt_reg;
	logic [12:0]                 addr_reg;
	logic [7:0]                  wdata_reg;
	logic [63:0]                 time_reg;
	logic [7:0]                  rdata_reg;
	logic                        rst_ctrl_reg;
	logic                        done_reg;
	logic [31:0]                 hrdata_reg;
	logic                        wr_pend_reg;
	logic [7:0]                  wr_addr_reg;
	logic [7:0]                  dq_s1_reg;
	logic [7:0]                  dq_s2_reg;
	logic [7:0]                  dq_s3_reg;

	// ==========================================================
	// ahb decode
	wire       addr_phase = hsel && hready && htrans[1];
	wire       wr_ctrl    = wr_pend_reg && (wr_addr_reg == rtc_host_pkg::OFS_CTRL);
	wire       idle       = (state_reg == rtc_host_pkg::ST_IDLE);
	wire       start      = wr_ctrl && hwdata[rtc_host_pkg::CTRL_START] && idle;
	wire       done_clr   = wr_pend_reg && (wr_addr_reg == rtc_host_pkg::OFS_STATUS)
	                        && hwdata[rtc_host_pkg::STAT_DONE];
	wire       wr_idle    = wr_pend_reg && idle;
	wire [31:0] status_w  = {30'h0000_0000, done_reg, !idle};

	function automatic logic [31:0] read_mux(input logic [7:0] a);
		unique case (a)
			rtc_host_pkg::OFS_CTRL:    read_mux = {28'h000_0000, rst_ctrl_reg, op_reg, 1'b0};
			rtc_host_pkg::OFS_STATUS:  read_mux = status_w;
			rtc_host_pkg::OFS_ADDR:    read_mux = {19'h0_0000, addr_reg};
			rtc_host_pkg::OFS_WDATA:   read_mux = {24'h00_0000, wdata_reg};
			rtc_host_pkg::OFS_TIME_LO: read_mux = time_reg[31:0];
			rtc_host_pkg::OFS_TIME_HI: read_mux = time_reg[63:32];
			rtc_host_pkg::OFS_RDATA:   read_mux = {24'h00_0000, rdata_reg};
			default:                   read_mux = 32'h0000_0000;
		endcase
	endfunction : read_mux

	// ==========================================================
	// sequence decode
	wire       is_ram   = op_reg[1];
	wire       is_rd    = is_ram ? (op_reg == rtc_host_pkg::OP_RAM_READ)
	                    : ((step_reg == rtc_host_pkg::STEP_OPEN)
	                    || ((step_reg >= rtc_host_pkg::STEP_DATA0)
	                    && (op_reg == rtc_host_pkg::OP_CLK_READ)));
	wire       in_key   = !is_ram && (step_reg != rtc_host_pkg::STEP_OPEN)
	                    && (step_reg < rtc_host_pkg::STEP_DATA0);
	wire [5:0] bit_idx  = step_reg[5:0] - 6'd1;
	wire       last     = is_ram || (step_reg == rtc_host_pkg::STEP_LAST);
	wire       dq_ok    = (dq_s2_reg == dq_s3_reg);
	wire       str_end  = (state_reg == rtc_host_pkg::ST_STROBE) && (cnt_reg == 3'd0)
	                    && !(is_rd && !dq_ok);
	wire       key_bit  = KEY[bit_idx];
	wire [7:0] drv_byte = is_ram ? wdata_reg
	                    : {7'h00, in_key ? key_bit : time_reg[bit_idx]};

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;
	assign sram_out  = pins_reg;
	assign rst_pin_n = !rst_ctrl_reg;

	// ==========================================================
	// bus slave registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg  <= 1'b0;
			wr_addr_reg  <= 8'h00;
			hrdata_reg   <= 32'h0000_0000;
			rst_ctrl_reg <= 1'b0;
			op_reg       <= rtc_host_pkg::OP_CLK_READ;
			addr_reg     <= rtc_host_pkg::ADDR_RESET;
			wdata_reg    <= 8'h00;
			done_reg     <= 1'b0;
		end else begin
			wr_pend_reg <= addr_phase && hwrite;
			wr_addr_reg <= haddr;
			if (addr_phase && !hwrite) begin
				hrdata_reg <= read_mux(haddr);
			end
			if (wr_ctrl) begin
				rst_ctrl_reg <= hwdata[rtc_host_pkg::CTRL_RST];
			end
			if (wr_ctrl && idle) begin
				op_reg <= rtc_host_pkg::op_e'(hwdata[rtc_host_pkg::CTRL_OP_LO +: 2]);
			end
			if (wr_idle && (wr_addr_reg == rtc_host_pkg::OFS_ADDR)) begin
				addr_reg <= hwdata[12:0];
			end
			if (wr_idle && (wr_addr_reg == rtc_host_pkg::OFS_WDATA)) begin
				wdata_reg <= hwdata[7:0];
			end
			// set wins over clear
			if ((state_reg == rtc_host_pkg::ST_RECOV) && last) begin
				done_reg <= 1'b1;
			end else if (done_clr) begin
				done_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// data line synchroniser, three stages
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dq_s1_reg <= 8'h00;
			dq_s2_reg <= 8'h00;
			dq_s3_reg <= 8'h00;
		end else begin
			dq_s1_reg <= dq_in;
			dq_s2_reg <= dq_s1_reg;
			dq_s3_reg <= dq_s2_reg;
		end
	end

	// ==========================================================
	// time buffer: software load or serial capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			time_reg  <= 64'h0000_0000_0000_0000;
			rdata_reg <= 8'h00;
		end else begin
			if (wr_idle && (wr_addr_reg == rtc_host_pkg::OFS_TIME_LO)) begin
				time_reg[31:0] <= hwdata;
			end
			if (wr_idle && (wr_addr_reg == rtc_host_pkg::OFS_TIME_HI)) begin
				time_reg[63:32] <= hwdata;
			end
			if (str_end && is_rd && !is_ram && !in_key
			    && (step_reg != rtc_host_pkg::STEP_OPEN)) begin
				time_reg[bit_idx] <= dq_s3_reg[0];
			end
			if (str_end && is_rd && is_ram) begin
				rdata_reg <= dq_s3_reg;
			end
		end
	end

	// ==========================================================
	// cycle sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= rtc_host_pkg::ST_IDLE;
			step_reg  <= 8'h00;
			cnt_reg   <= 3'd0;
			pins_reg  <= '{1'b1, 1'b1, 1'b1, 13'h0000, 8'h00, 1'b0};
		end else begin
			unique case (state_reg)
				rtc_host_pkg::ST_IDLE: begin
					if (start) begin
						state_reg <= rtc_host_pkg::ST_SETUP;
						step_reg  <= rtc_host_pkg::STEP_OPEN;
						pins_reg.addr <= addr_reg;
					end
				end
				rtc_host_pkg::ST_SETUP: begin
					state_reg       <= rtc_host_pkg::ST_STROBE;
					cnt_reg         <= is_rd ? rtc_host_pkg::RD_STROBE_LAST
					                         : rtc_host_pkg::WR_STROBE_LAST;
					pins_reg.ce_n   <= 1'b0;
					pins_reg.oe_n   <= !is_rd;
					pins_reg.we_n   <= is_rd;
					pins_reg.dq_out <= drv_byte;
					pins_reg.dq_oe  <= !is_rd;
				end
				rtc_host_pkg::ST_STROBE: begin
					if (str_end) begin
						state_reg     <= rtc_host_pkg::ST_RECOV;
						pins_reg.ce_n <= 1'b1;
						pins_reg.oe_n <= 1'b1;
						pins_reg.we_n <= 1'b1;
					end else if (cnt_reg != 3'd0) begin
						cnt_reg <= cnt_reg - 3'd1;
					end
				end
				rtc_host_pkg::ST_RECOV: begin
					// whole groups: clock transfers stop only after bit 63, ram transfers after their one byte
					pins_reg.dq_oe <= 1'b0;
					state_reg      <= last ? rtc_host_pkg::ST_IDLE : rtc_host_pkg::ST_SETUP;
					step_reg       <= last ? step_reg : step_reg + 8'd1;
				end
			endcase
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_open_read;
		(state_reg == rtc_host_pkg::ST_SETUP) && !is_ram && (step_reg == 8'h00)
		|=> !pins_reg.ce_n && !pins_reg.oe_n && pins_reg.we_n;
	endproperty
	a_open_read: assert property (p_open_read) else $error("opening read missing");

	property p_key_bit;
		(state_reg == rtc_host_pkg::ST_SETUP) && in_key
		|=> !pins_reg.we_n && pins_reg.dq_oe && (pins_reg.dq_out[0] == KEY[$past(bit_idx)]);
	endproperty
	a_key_bit: assert property (p_key_bit) else $error("key bit wrong");

	property p_scratch;
		$fell(pins_reg.ce_n) |-> (pins_reg.addr == $past(pins_reg.addr));
	endproperty
	a_scratch: assert property (p_scratch) else $error("address moved in sequence");

	property p_data_wr;
		(state_reg == rtc_host_pkg::ST_SETUP) && !is_ram && !is_rd && !in_key
		|=> !pins_reg.we_n && (pins_reg.dq_out[0] == time_reg[$past(bit_idx)]);
	endproperty
	a_data_wr: assert property (p_data_wr) else $error("data bit wrong");

	property p_group;
		$rose(done_reg) && !is_ram |-> (step_reg == rtc_host_pkg::STEP_LAST);
	endproperty
	a_group: assert property (p_group) else $error("transfer cut short");

	property p_order;
		(state_reg == rtc_host_pkg::ST_RECOV) && !last
		|=> (state_reg == rtc_host_pkg::ST_SETUP) && (step_reg == $past(step_reg) + 8'd1);
	endproperty
	a_order: assert property (p_order) else $error("step order broken");

	property p_read_free;
		!pins_reg.ce_n && pins_reg.we_n |-> !pins_reg.dq_oe;
	endproperty
	a_read_free: assert property (p_read_free) else $error("driving during read");

	property p_write_edges;
		$fell(pins_reg.we_n) |-> $fell(pins_reg.ce_n) ##1 pins_reg.dq_oe [*1];
	endproperty
	a_write_edges: assert property (p_write_edges) else $error("write strobes apart");

endmodule : rtc_host

// file: verilog/rtc_host_pkg.sv
package rtc_host_pkg;

	// ==========================================================
	// timing
	localparam int CLK_NS      = 100;
	localparam int T_ACC_NS    = 120;
	localparam int T_WP_NS     = 100;
	localparam int SYNC_STAGES = 3;
	localparam int ACC_CYC     = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [2:0] RD_STROBE_LAST = 3'(ACC_CYC + SYNC_STAGES - 1);
	localparam logic [2:0] WR_STROBE_LAST = 3'(WP_CYC - 1);

	// ==========================================================
	// sequence steps: 0 opening read, 1..64 key, 65..128 data
	localparam int ADDR_W = 13;
	localparam logic [7:0] STEP_OPEN  = 8'h00;
	localparam logic [7:0] STEP_DATA0 = 8'h41;
	localparam logic [7:0] STEP_LAST  = 8'h80;

	// ==========================================================
	// register offsets and fields
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_ADDR    = 8'h08;
	localparam logic [7:0] OFS_WDATA   = 8'h0C;
	localparam logic [7:0] OFS_TIME_LO = 8'h10;
	localparam logic [7:0] OFS_TIME_HI = 8'h14;
	localparam logic [7:0] OFS_RDATA   = 8'h18;
	localparam int CTRL_START  = 0;
	localparam int CTRL_OP_LO  = 1;
	localparam int CTRL_RST    = 3;
	localparam int STAT_BUSY   = 0;
	localparam int STAT_DONE   = 1;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;

	typedef enum logic [1:0] {
		OP_CLK_READ  = 2'b00,
		OP_CLK_WRITE = 2'b01,
		OP_RAM_READ  = 2'b10,
		OP_RAM_WRITE = 2'b11
	} op_e;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SETUP  = 2'b01,
		ST_STROBE = 2'b10,
		ST_RECOV  = 2'b11
	} state_e;

	typedef struct packed {
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        dq_out;
		logic              dq_oe;
	} sram_out_s;

endpackage : rtc_host_pkg
